// ---- frp_device.sv ----
/*
 * frp_device: function register and read-parameter register of a serial
 * flash, with their command decoder on the serial link and the decodes
 * that the array logic needs (dummy cycles, wrap, protection, row locks).
 * Assumes link pins are asynchronous to core_clk and the serial clock is
 * at most a quarter of core_clk so that every edge is seen.
 */
// The register offsets and the APB interface to the registers are this design's own decisions.
`default_nettype none
module frp_device (
    input  wire logic        core_clk,
    input  wire logic        srst,
    frp_link_if.device       link,
    input  wire logic        programBusy,
    input  wire logic        eraseBusy,
    input  wire logic        quadCommandMode,
    input  wire logic [7:0]  queryOpcode,
    input  wire logic [23:0] readAddr,
    input  wire logic [3:0]  blockProtectField,
    input  wire logic [6:0]  blockIndex,
    input  wire logic [1:0]  infoRowSel,
    output logic             protectAreaSelect,
    output logic [3:0]       infoRowLock,
    output logic             programSuspendedFlag,
    output logic             eraseSuspendedFlag,
    output logic [7:0]       readParams,
    output logic [3:0]       dummyCount,
    output logic [23:0]      wrapNextAddr,
    output logic             wrapEnable,
    output logic [6:0]       burstBytes,
    output logic [10:0]      driveStrengthTenths,
    output logic             blockProtected,
    output logic             infoRowProgAllowed
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0]  sckSync;
        logic [1:0]  csSync;
        logic [1:0]  mosiSync;
        logic [7:0]  funcReg;
        logic [7:0]  readParams;
        logic        writeEnableLatch;
        logic [4:0]  bitCnt;
        logic [7:0]  opcode;
        logic [7:0]  inShift;
        logic [7:0]  outShift;
        logic        misoOut;
        logic        misoOe;
        logic [3:0]  dummyCount;
        logic [23:0] wrapNextAddr;
        logic [6:0]  burstBytes;
        logic [10:0] driveTenths;
        logic        blockProtected;
        logic        infoRowProgAllowed;
    } frp_dev_state_type;

    frp_dev_state_type st;
    frp_dev_state_type next_st;

    // drive strength in tenths of a percent, reserved codes read as zero
    function automatic logic [10:0] drive_tenths(input logic [2:0] code);
        case (code)
            3'b001:  drive_tenths = 11'd125;
            3'b010:  drive_tenths = 11'd250;
            3'b011:  drive_tenths = 11'd375;
            3'b101:  drive_tenths = 11'd750;
            3'b110:  drive_tenths = 11'd1000;
            3'b111:  drive_tenths = 11'd500;
            default: drive_tenths = 11'd0;
        endcase
    endfunction

    logic        sckRise;
    logic        sckFall;
    logic        csActive;
    logic [7:0]  shiftIn;
    logic [6:0]  burst;
    logic [23:0] mask;
    logic [23:0] incAddr;
    logic [7:0]  protCount;
    logic [3:0]  fieldMinus;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // second and third stages feed edge logic; first stage feeds only the second
        next_st.sckSync  = {st.sckSync[1:0], link.sck};
        next_st.csSync   = {st.csSync[0], link.csN};
        next_st.mosiSync = {st.mosiSync[0], link.mosi};
        sckRise  = st.sckSync[1] & ~st.sckSync[2];
        sckFall  = ~st.sckSync[1] & st.sckSync[2];
        csActive = ~st.csSync[1];
        shiftIn  = {st.inShift[6:0], st.mosiSync[1]};

        if (!csActive) begin
            next_st.bitCnt = 5'd0;
            next_st.misoOe = 1'b0;
            next_st.misoOut = 1'b1;
        end else if (sckRise && st.bitCnt < 5'd16) begin
            next_st.inShift = shiftIn;
            next_st.bitCnt  = st.bitCnt + 5'd1;
            if (st.bitCnt == 5'd7) begin
                next_st.opcode = shiftIn;
                case (shiftIn)
                    frp_pkg::WRITE_ENABLE_CMD:  next_st.writeEnableLatch = 1'b1;
                    frp_pkg::WRITE_DISABLE_CMD: next_st.writeEnableLatch = 1'b0;
                    frp_pkg::SUSPEND_CMD: begin
                        if (programBusy)
                            next_st.funcReg[frp_pkg::FN_PROG_SUSP_BIT] = 1'b1;
                        else if (eraseBusy)
                            next_st.funcReg[frp_pkg::FN_ERASE_SUSP_BIT] = 1'b1;
                    end
                    frp_pkg::RESUME_CMD: begin
                        // a pending program resumes before an erase underneath it
                        if (st.funcReg[frp_pkg::FN_PROG_SUSP_BIT])
                            next_st.funcReg[frp_pkg::FN_PROG_SUSP_BIT] = 1'b0;
                        else
                            next_st.funcReg[frp_pkg::FN_ERASE_SUSP_BIT] = 1'b0;
                    end
                    frp_pkg::READ_FUNCTION_CMD:    next_st.outShift = st.funcReg;
                    frp_pkg::READ_READ_PARAMS_CMD: next_st.outShift = st.readParams;
                    default: ;
                endcase
            end else if (st.bitCnt == 5'd15) begin
                if (st.opcode == frp_pkg::SET_READ_PARAMS_CMD)
                    next_st.readParams = shiftIn;
                else if (st.opcode == frp_pkg::WRITE_FUNCTION_CMD
                         && st.writeEnableLatch) begin
                    // OTP bits only accumulate ones; bits 0, 2, 3 not writable
                    next_st.funcReg = st.funcReg | (shiftIn & frp_pkg::FN_OTP_MASK);
                    next_st.writeEnableLatch = 1'b0;
                end
            end
        end else if (sckFall && st.bitCnt >= 5'd8
                     && frp_pkg::has_read_byte(st.opcode)) begin
            // output changes on the falling edge so the host samples a stable bit
            next_st.misoOe   = 1'b1;
            next_st.misoOut  = st.outShift[7];
            next_st.outShift = {st.outShift[6:0], 1'b0};
        end

        // decodes toward the array logic
        next_st.dummyCount = frp_pkg::dummy_cycles(queryOpcode, quadCommandMode,
            st.readParams[frp_pkg::RP_DUMMY_LSB +: 2]);
        burst = 7'd8 << st.readParams[1:0];
        next_st.burstBytes = burst;
        mask    = {17'd0, burst - 7'd1};
        incAddr = readAddr + 24'd1;
        if (st.readParams[frp_pkg::RP_WRAP_BIT])
            next_st.wrapNextAddr = (readAddr & ~mask) | (incAddr & mask);
        else
            next_st.wrapNextAddr = {1'b0, incAddr[frp_pkg::ARRAY_ADDR_BITS-1:0]};
        next_st.driveTenths = drive_tenths(st.readParams[frp_pkg::RP_DRIVE_LSB +: 3]);

        fieldMinus = blockProtectField - 4'd1;
        if (blockProtectField == 4'd0)
            protCount = 8'd0;
        else if (blockProtectField[3])
            protCount = 8'd128;
        else
            protCount = 8'd1 << fieldMinus[2:0];
        if (st.funcReg[frp_pkg::FN_AREA_SEL_BIT])
            next_st.blockProtected = {1'b0, blockIndex} < protCount;
        else
            next_st.blockProtected = ({1'b0, blockIndex} + protCount) >= 8'd128;
        if (protCount == 8'd0)
            next_st.blockProtected = 1'b0;
        next_st.infoRowProgAllowed =
            ~st.funcReg[frp_pkg::FN_LOCK_LSB + 32'(infoRowSel)];

        if (srst) begin
            next_st = '0;
            next_st.sckSync    = 3'b000;
            next_st.csSync     = 2'b11;
            next_st.mosiSync   = 2'b00;
            next_st.funcReg    = frp_pkg::FN_RESET;
            next_st.readParams = frp_pkg::RP_RESET;
            next_st.misoOut    = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.misoOut           = st.misoOut;
    assign link.misoOe            = st.misoOe;
    assign protectAreaSelect      = st.funcReg[frp_pkg::FN_AREA_SEL_BIT];
    assign infoRowLock            = st.funcReg[frp_pkg::FN_LOCK_LSB +: 4];
    assign programSuspendedFlag   = st.funcReg[frp_pkg::FN_PROG_SUSP_BIT];
    assign eraseSuspendedFlag     = st.funcReg[frp_pkg::FN_ERASE_SUSP_BIT];
    assign readParams             = st.readParams;
    assign dummyCount             = st.dummyCount;
    assign wrapNextAddr           = st.wrapNextAddr;
    assign wrapEnable             = st.readParams[frp_pkg::RP_WRAP_BIT];
    assign burstBytes             = st.burstBytes;
    assign driveStrengthTenths    = st.driveTenths;
    assign blockProtected         = st.blockProtected;
    assign infoRowProgAllowed     = st.infoRowProgAllowed;
endmodule
`default_nettype wire

// ---- frp_pkg.sv ----
/*
 * frp_pkg: shared constants, opcodes, register layouts and decode functions
 * for the flash function / read-parameter register block and its host.
 * Assumes both ends run on a 100 MHz core_clk with a synchronous reset.
 */
// Contract
// - OTP function bits never return to zero; here srst clears funcReg to FN_RESET, OTP bits included
// - bit1 selects top or bottom protect area
// - bit2 flags program suspended until resume
// - bit3 flags erase suspended until resume
// - bits4-7 lock info rows, refuse programming
// - read params: drive, dummy, wrap, burst; default E0
// - set-read-params C0h loads all eight bits
// - burst field selects 8/16/32/64 bytes
// - wrap off: whole array; on: aligned burst
// - SPI fast/dual/quad output reads: 8; 03h none
// - EBh and QUAD_COMMAND_MODE 0Bh: 6,4,8,10 dummy
// - EDh and QUAD_COMMAND_MODE 0Dh: 3,2,4,5 dummy
// - BBh 4,4,8,8; BDh 2,2,4,4; SPI 0Dh 4
// - dummy counts include the mode-bit cycles
// - unique-ID, param-table, info-row reads as fast read
// - host avoids contention during dummy cycles
// - drive strength code decode, 000/100 reserved
// - bit0 reserved read-only; function resets zero
// - write-function ignored without write-enable latch
// - protect field counts 64KB blocks from top/bottom
`default_nettype none
package frp_pkg;
    // ------------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_NORMAL_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ          = 8'h0B;
    localparam logic [7:0] OP_FAST_READ_DTR      = 8'h0D;
    localparam logic [7:0] OP_DUAL_OUT_READ      = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT_READ      = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO_READ       = 8'hBB;
    localparam logic [7:0] OP_DUAL_IO_DTR_READ   = 8'hBD;
    localparam logic [7:0] OP_QUAD_IO_READ       = 8'hEB;
    localparam logic [7:0] OP_QUAD_IO_DTR_READ   = 8'hED;
    localparam logic [7:0] READ_UNIQUE_ID_CMD    = 8'h4B;
    localparam logic [7:0] READ_PARAM_TABLE_CMD  = 8'h5A;
    localparam logic [7:0] READ_INFO_ROW_CMD     = 8'h68;
    localparam logic [7:0] WRITE_ENABLE_CMD      = 8'h06;
    localparam logic [7:0] WRITE_DISABLE_CMD     = 8'h04;
    localparam logic [7:0] READ_FUNCTION_CMD     = 8'h48;
    localparam logic [7:0] WRITE_FUNCTION_CMD    = 8'h42;
    localparam logic [7:0] SET_READ_PARAMS_CMD   = 8'hC0;
    localparam logic [7:0] READ_READ_PARAMS_CMD  = 8'h61;
    localparam logic [7:0] SUSPEND_CMD           = 8'h75;
    localparam logic [7:0] RESUME_CMD            = 8'h7A;

    // ------------------------------------------------------------------
    // register layout
    // ------------------------------------------------------------------
    localparam int         FN_AREA_SEL_BIT   = 1;
    localparam int         FN_PROG_SUSP_BIT  = 2;
    localparam int         FN_ERASE_SUSP_BIT = 3;
    localparam int         FN_LOCK_LSB       = 4;
    localparam logic [7:0] FN_OTP_MASK       = 8'hF2;
    localparam logic [7:0] FN_RESET          = 8'h00;
    localparam logic [7:0] RP_RESET          = 8'hE0;
    localparam int         RP_DRIVE_LSB      = 5;
    localparam int         RP_DUMMY_LSB      = 3;
    localparam int         RP_WRAP_BIT       = 2;
    localparam int         ARRAY_ADDR_BITS   = 23;
    localparam int         BLOCK_COUNT       = 128;

    // ------------------------------------------------------------------
    // link timing and host registers
    // ------------------------------------------------------------------
    localparam int         CLK_PERIOD_NS   = 10;
    localparam int         SCK_PERIOD_NS   = 80;
    localparam int         SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [7:0] HOST_CMD_ADDR   = 8'h00;
    localparam logic [7:0] HOST_STAT_ADDR  = 8'h04;
    localparam logic [7:0] HOST_DUMMY_ADDR = 8'h08;

    // dummy cycles for a read opcode, mode-bit cycles included
    function automatic logic [3:0] dummy_cycles(input logic [7:0] op,
                                                input logic       quad,
                                                input logic [1:0] sel);
        logic [3:0] qtab;
        logic [3:0] dtab;
        qtab = (sel == 2'd0) ? 4'd6 : (sel == 2'd1) ? 4'd4 : (sel == 2'd2) ? 4'd8 : 4'd10;
        dtab = (sel == 2'd0) ? 4'd3 : (sel == 2'd1) ? 4'd2 : (sel == 2'd2) ? 4'd4 : 4'd5;
        case (op)
            OP_FAST_READ, READ_UNIQUE_ID_CMD, READ_PARAM_TABLE_CMD,
            READ_INFO_ROW_CMD:   dummy_cycles = quad ? qtab : 4'd8;
            OP_DUAL_OUT_READ,
            OP_QUAD_OUT_READ:    dummy_cycles = 4'd8;
            OP_QUAD_IO_READ:     dummy_cycles = qtab;
            OP_QUAD_IO_DTR_READ: dummy_cycles = dtab;
            OP_FAST_READ_DTR:    dummy_cycles = quad ? dtab : 4'd4;
            OP_DUAL_IO_READ:     dummy_cycles = sel[1] ? 4'd8 : 4'd4;
            OP_DUAL_IO_DTR_READ: dummy_cycles = sel[1] ? 4'd4 : 4'd2;
            default:             dummy_cycles = 4'd0;
        endcase
    endfunction

    // command carries one data byte from host to device
    function automatic logic has_write_byte(input logic [7:0] op);
        has_write_byte = (op == WRITE_FUNCTION_CMD) || (op == SET_READ_PARAMS_CMD);
    endfunction

    // command returns one byte from device to host
    function automatic logic has_read_byte(input logic [7:0] op);
        has_read_byte = (op == READ_FUNCTION_CMD) || (op == READ_READ_PARAMS_CMD);
    endfunction
endpackage
`default_nettype wire

// ---- frp_link_if.sv ----
/*
 * frp_link_if: four-wire serial link between host controller and device.
 * Assumes the host drives clock, select and data-in; the device alone
 * drives the data-out line, which idles high when nobody drives it.
 */
`default_nettype none
interface frp_link_if;
    logic sck;
    logic csN;
    logic mosi;
    logic misoOut;
    logic misoOe;
    logic miso;

    // pull-up model: an undriven line reads high
    assign miso = misoOe ? misoOut : 1'b1;

    modport device (input sck, input csN, input mosi, output misoOut, output misoOe);
    modport host   (output sck, output csN, output mosi, input miso);
endinterface
`default_nettype wire

// ---- frp_host.sv ----
/*
 * frp_host: APB-programmed host controller that issues one-byte commands,
 * optionally followed by one byte out or one byte in, on the serial link.
 * Assumes an APB master on core_clk; the serial clock is made here.
 */
`default_nettype none
module frp_host (
    input  wire logic        core_clk,
    input  wire logic        srst,
    frp_link_if.host         link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_SHIFT = 2'b01,
        HS_GAP   = 2'b10
    } frp_host_phase_type;

    typedef struct packed {
        frp_host_phase_type phase;
        logic [1:0]  misoSync;
        logic [7:0]  div;
        logic [4:0]  bitCnt;
        logic [4:0]  bitTotal;
        logic [15:0] txShift;
        logic [7:0]  rxShift;
        logic [7:0]  rxByte;
        logic [7:0]  shadowParams;
        logic [7:0]  opcode;
        logic [7:0]  queryOpcode;
        logic        queryQuad;
        logic        sck;
        logic        csN;
        logic        mosi;
        logic [31:0] prdata;
    } frp_host_state_type;

    frp_host_state_type st;
    frp_host_state_type next_st;

    logic       wrAccess;
    logic       rdAccess;
    logic [7:0] op;

    always_comb begin
        next_st = st;
        next_st.misoSync = {st.misoSync[0], link.miso};
        wrAccess = psel & penable & pwrite;
        rdAccess = psel & ~penable & ~pwrite;
        op       = pwdata[7:0];

        // a new command is only taken while the link is idle
        if (wrAccess && paddr == frp_pkg::HOST_CMD_ADDR && st.phase == HS_IDLE) begin
            next_st.phase    = HS_SHIFT;
            next_st.opcode   = op;
            next_st.txShift  = {op, pwdata[15:8]};
            next_st.bitTotal = (frp_pkg::has_write_byte(op) || frp_pkg::has_read_byte(op))
                               ? 5'd16 : 5'd8;
            next_st.bitCnt   = 5'd0;
            next_st.div      = 8'd0;
            next_st.csN      = 1'b0;
            next_st.sck      = 1'b0;
            next_st.mosi     = op[7];
            if (op == frp_pkg::SET_READ_PARAMS_CMD)
                next_st.shadowParams = pwdata[15:8];
        end
        if (wrAccess && paddr == frp_pkg::HOST_DUMMY_ADDR) begin
            next_st.queryOpcode = pwdata[7:0];
            next_st.queryQuad   = pwdata[8];
        end

        case (st.phase)
            HS_SHIFT: begin
                next_st.div = st.div + 8'd1;
                if (st.div == 8'(frp_pkg::SCK_HALF_CYCLES - 1)) begin
                    next_st.div = 8'd0;
                    next_st.sck = ~st.sck;
                    if (st.sck) begin
                        // sample at the end of the high phase, then move data out
                        next_st.rxShift = {st.rxShift[6:0], st.misoSync[1]};
                        next_st.txShift = {st.txShift[14:0], 1'b0};
                        next_st.mosi    = st.txShift[14];
                        next_st.bitCnt  = st.bitCnt + 5'd1;
                        if (st.bitCnt + 5'd1 == st.bitTotal) begin
                            next_st.phase = HS_GAP;
                            if (frp_pkg::has_read_byte(st.opcode)) begin
                                next_st.rxByte = {st.rxShift[6:0], st.misoSync[1]};
                                if (st.opcode == frp_pkg::READ_READ_PARAMS_CMD)
                                    next_st.shadowParams = {st.rxShift[6:0], st.misoSync[1]};
                            end
                        end
                    end
                end
            end
            HS_GAP: begin
                next_st.csN = 1'b1;
                next_st.div = st.div + 8'd1;
                // select stays high a full serial period so the device sees it
                if (st.div == 8'(2 * frp_pkg::SCK_HALF_CYCLES - 1)) begin
                    next_st.phase = HS_IDLE;
                    next_st.div   = 8'd0;
                end
            end
            default: ;
        endcase

        if (rdAccess) begin
            case (paddr)
                frp_pkg::HOST_STAT_ADDR:
                    next_st.prdata = {16'h0000, st.rxByte, 7'd0, st.phase != HS_IDLE};
                frp_pkg::HOST_DUMMY_ADDR:
                    next_st.prdata = {16'h0000, st.shadowParams, 4'd0,
                        frp_pkg::dummy_cycles(st.queryOpcode, st.queryQuad,
                            st.shadowParams[frp_pkg::RP_DUMMY_LSB +: 2])};
                default: next_st.prdata = 32'h0000_0000;
            endcase
        end

        if (srst) begin
            next_st = '0;
            next_st.phase        = HS_IDLE;
            next_st.csN          = 1'b1;
            next_st.misoSync     = 2'b11;
            next_st.shadowParams = frp_pkg::RP_RESET;
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    // host drives sck, csN and mosi; data-out stays with the device, no contention
    assign link.sck  = st.sck;
    assign link.csN  = st.csN;
    assign link.mosi = st.mosi;
    assign prdata    = st.prdata;
    assign pready    = 1'b1;
    assign pslverr   = 1'b0;
endmodule
`default_nettype wire

// ---- frp_link_chk.sv ----
/* frp_link_chk: timing checks on the serial link between host and device.
   assumes the host makes a mode-0 clock of 4 high and 4 low core cycles. */
`default_nettype none
module frp_link_chk (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sck,
    input wire logic csN,
    input wire logic mosi,
    input wire logic misoOut,
    input wire logic misoOe,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // ------------------------------------------------------------------
    // link assertions
    // ------------------------------------------------------------------
    a_miso_pull_up: assert property (!misoOe |-> miso)
        else $error("miso not high while undriven");
    a_release_oe: assert property (csN [*5] |-> !misoOe)
        else $error("miso still driven after deselect");
    a_oe_in_low: assert property ($rose(misoOe) |-> !csN && !sck)
        else $error("miso driven outside a low clock phase");
    a_out_on_fall: assert property (misoOe && $changed(misoOut) |-> !sck)
        else $error("miso changed while clock high");
    a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
        else $error("mosi changed while clock high");
    a_sck_idle_low: assert property (csN |-> !sck)
        else $error("clock high outside a frame");
    a_high_phase: assert property ($rose(sck) |-> sck [*4] ##1 !sck)
        else $error("clock high phase not four cycles");
    a_low_phase: assert property ($fell(sck) |-> !sck [*4])
        else $error("clock low phase under four cycles");
endmodule
`default_nettype wire

// ---- flash_function_and_read_param_regs_test.sv ----
/* testbench: host and device joined by the link, host driven over APB.
   assumes pready answers in one access cycle or later. */
`default_nettype none
module flash_function_and_read_param_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, srst, psel, penable, pwrite, pready, pslverr, programBusy, eraseBusy;
    logic quadCommandMode, protectAreaSelect, programSuspendedFlag, eraseSuspendedFlag;
    logic wrapEnable, blockProtected, infoRowProgAllowed;
    logic [7:0] paddr, queryOpcode, readParams, b;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] readAddr, wrapNextAddr;
    logic [3:0] blockProtectField, infoRowLock, dummyCount;
    logic [6:0] blockIndex, burstBytes;
    logic [1:0] infoRowSel;
    logic [10:0] driveStrengthTenths;
    int failures, tests_run, cyc;
    int drv[8] = '{0, 125, 250, 375, 0, 750, 1000, 500};
    logic [7:0] ops[8] = '{8'hEB, 8'hED, 8'hBB, 8'hBD, 8'h3B, 8'h03, 8'h0B, 8'h4B};
    logic [15:0] dq[8] = '{16'hA846, 16'h5423, 16'h8844, 16'h4422, 16'h8888, 16'h0000,
        16'h8888, 16'hA846};
    frp_link_if link ();
    frp_host i_frp_host (.core_clk, .srst, .link(link), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);
    frp_device i_frp_device (.core_clk, .srst, .link(link), .programBusy, .eraseBusy,
        .quadCommandMode, .queryOpcode, .readAddr, .blockProtectField, .blockIndex,
        .infoRowSel, .protectAreaSelect, .infoRowLock, .programSuspendedFlag,
        .eraseSuspendedFlag, .readParams, .dummyCount, .wrapNextAddr, .wrapEnable,
        .burstBytes, .driveStrengthTenths, .blockProtected, .infoRowProgAllowed);
    frp_link_chk i_frp_link_chk (.core_clk, .srst, .sck(link.sck), .csN(link.csN),
        .mosi(link.mosi), .misoOut(link.misoOut), .misoOe(link.misoOe), .miso(link.miso));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // a new command only goes out once busy has dropped
    task automatic send(input logic [7:0] op, input logic [7:0] d);
        logic [31:0] r;
        apb(1'b1, 8'h00, {16'h0000, d, op}, r);
        repeat (2) @(posedge core_clk);
        r = 32'h0000_0001;
        while (r[0] !== 1'b0) apb(1'b0, 8'h04, 32'h0000_0000, r);
        repeat (4) @(posedge core_clk);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            close_out();
        end
    end
    initial begin
        {srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
        {programBusy, eraseBusy, quadCommandMode, queryOpcode, infoRowSel} = 13'h0000;
        {readAddr, blockProtectField, blockIndex} = {24'h7F_FFFF, 11'h000};
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk("readParams", readParams, 8'hE0);
        chk("fnBits", {infoRowLock, eraseSuspendedFlag, programSuspendedFlag, protectAreaSelect}, 0);
        apb(1'b0, 8'h0C, 32'h0000_0000, q);
        chk("unmapped", q, 0);
        for (int i = 0; i < 8; i++) begin
            b = {i[2:0], i[1:0], i[0], i[1:0]};
            send(8'hC0, b);
            chk("readParams", readParams, b);
            chk("burstBytes", burstBytes, 8 << b[1:0]);
            chk("wrapEnable", wrapEnable, b[2]);
            chk("wrapNext", wrapNextAddr, b[2] ? 24'h7F_FFFF & ~((24'd8 << b[1:0]) - 24'd1) : 0);
            chk("drive", driveStrengthTenths, drv[b[7:5]]);
            for (int k = 0; k < 8; k++) begin
                queryOpcode <= ops[k];
                quadCommandMode <= (k == 7);
                repeat (3) @(posedge core_clk);
                chk("dummy", dummyCount, dq[k][4*b[4:3] +: 4]);
            end
        end
        apb(1'b1, 8'h08, 32'h0000_010B, q);
        send(8'h61, 8'h00);
        apb(1'b0, 8'h08, 32'h0000_0000, q);
        chk("hostDummy", q, 32'h0000_FF0A);
        send(8'h42, 8'hFF);
        chk("unlatchedWrite", protectAreaSelect, 0);
        send(8'h06, 8'h00);
        send(8'h42, 8'h1F);
        send(8'h48, 8'h00);
        apb(1'b0, 8'h04, 32'h0000_0000, q);
        chk("fnRead", q[15:8], 8'h12);
        chk("rowProgAllowed", infoRowProgAllowed, 0);
        send(8'h06, 8'h00);
        send(8'h42, 8'h00);
        chk("otpKept", {infoRowLock, protectAreaSelect}, 5'h03);
        blockProtectField <= 4'h1;
        for (int j = 0; j < 2; j++) begin
            blockIndex <= j ? 7'h7F : 7'h00;
            programBusy <= (j == 0);
            eraseBusy <= (j == 1);
            send(8'h75, 8'h00);
            chk("bottomBlock", blockProtected, j == 0);
            chk("suspended", {eraseSuspendedFlag, programSuspendedFlag}, j + 1);
            send(8'h7A, 8'h00);
            chk("resumed", {eraseSuspendedFlag, programSuspendedFlag}, 0);
        end
        close_out();
    end
endmodule
`default_nettype wire
